// ===== mcs_pkg.sv
package mcs_pkg;

	localparam int NUM_BANKS  = 8;
	localparam int NUM_GROUPS = 4;
	localparam int CMP_LSB    = 15;

	// bank register layout, stride per bank
	localparam logic [7:0] BANK_STRIDE  = 8'h20;
	localparam logic [7:0] OFS_BASE_LO  = 8'h00;
	localparam logic [7:0] OFS_BASE_HI  = 8'h04;
	localparam logic [7:0] OFS_MASK_LO  = 8'h08;
	localparam logic [7:0] OFS_MASK_HI  = 8'h0C;
	localparam logic [7:0] OFS_CTRL     = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'hFC;

	// reset values
	localparam logic [11:0] BASE_HI_EVEN_RST = 12'hFC0;
	localparam logic [11:0] BASE_HI_ODD_RST  = 12'hFF0;
	localparam logic [15:0] BASE_LO_RST      = 16'h0000;
	localparam logic [15:0] MASK_HI_RST      = 16'hFFFF;
	localparam logic [15:0] MASK_LO_RST      = 16'h8000;

	// writable bits of the lower halves
	localparam logic [15:0] BASE_LO_KEEP = 16'h8000;
	localparam logic [15:0] MASK_LO_KEEP = 16'hE000;

	// control register fields
	localparam int STYLE_LSB = 8;
	localparam int WIDTH_LSB = 6;

	// bus timing styles
	localparam logic [3:0] STYLE_CARD_MEM   = 4'hB;
	localparam logic [3:0] STYLE_CARD_IO    = 4'hA;
	localparam logic [3:0] STYLE_M_IO       = 4'h9;
	localparam logic [3:0] STYLE_I_IO       = 4'h8;
	localparam logic [3:0] STYLE_LATCH_MEM  = 4'h2;
	localparam logic [3:0] STYLE_BUFFER_MEM = 4'h1;
	localparam logic [3:0] STYLE_REG_MEM    = 4'h0;

	// port width codes
	localparam logic [1:0] WIDTH_32 = 2'h0;
	localparam logic [1:0] WIDTH_8  = 2'h1;
	localparam logic [1:0] WIDTH_16 = 2'h2;
	localparam logic [1:0] WIDTH_64 = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum {
		SLOT_NONE, SLOT_BASE_LO, SLOT_BASE_HI,
		SLOT_MASK_LO, SLOT_MASK_HI, SLOT_CTRL, SLOT_STATUS
	} mcs_slot_t;

	typedef struct packed {
		logic [15:0] base_hi;
		logic [15:0] base_lo;
		logic [15:0] mask_hi;
		logic [15:0] mask_lo;
		logic [3:0]  style;
		logic [1:0]  width;
	} mcs_bank_regs_t;

	typedef struct packed {
		logic [3:0] style;
		logic [1:0] width;
	} mcs_sel_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} mcs_axi_m2s_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mcs_axi_s2m_t;

endpackage

// ===== mcs_bank.sv
`timescale 1ns/1ps
module mcs_bank
	import mcs_pkg::*;
#(
	parameter logic [2:0] BANK = 3'h0
) (
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  wire logic           interleave_boot,
	input  wire logic [1:0]     boot_width,
	input  wire logic           wr_en,
	input  mcs_slot_t           wr_slot,
	input  wire logic [15:0]    wr_data,
	input  wire logic [1:0]     wr_strb,
	input  wire logic [3:0]     grp_base_top,
	input  wire logic [3:0]     grp_mask_top,
	input  wire logic [31:0]    mem_addr,
	output mcs_bank_regs_t      regs,
	output logic                hit
);

	localparam logic [3:0] GRP_TOP = {2'h0, BANK[2:1]} + 4'h1;

	logic [16:0] eff_base;
	logic [16:0] eff_mask;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		merge = {strb[1] ? nw[15:8] : old[15:8],
			strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	// base pair, odd bank follows even when interleaved at boot
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regs.base_lo <= BASE_LO_RST;
			if (BANK[0] && !interleave_boot) begin
				regs.base_hi <= {GRP_TOP, BASE_HI_ODD_RST};
			end else begin
				regs.base_hi <= {GRP_TOP, BASE_HI_EVEN_RST};
			end
		end else if (wr_en && wr_slot == SLOT_BASE_HI) begin
			regs.base_hi <= merge(regs.base_hi, wr_data, wr_strb);
		end else if (wr_en && wr_slot == SLOT_BASE_LO) begin
			regs.base_lo <= merge(regs.base_lo, wr_data, wr_strb)
				& BASE_LO_KEEP;
		end
	end

	// mask pair
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regs.mask_hi <= MASK_HI_RST;
			regs.mask_lo <= MASK_LO_RST;
		end else if (wr_en && wr_slot == SLOT_MASK_HI) begin
			regs.mask_hi <= merge(regs.mask_hi, wr_data, wr_strb);
		end else if (wr_en && wr_slot == SLOT_MASK_LO) begin
			regs.mask_lo <= merge(regs.mask_lo, wr_data, wr_strb)
				& MASK_LO_KEEP;
		end
	end

	// control, may change at any time
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regs.style <= interleave_boot ? STYLE_LATCH_MEM
				: STYLE_REG_MEM;
			regs.width <= ~boot_width;
		end else if (wr_en && wr_slot == SLOT_CTRL) begin
			if (wr_strb[1]) begin
				regs.style <= wr_data[STYLE_LSB +: 4];
			end
			if (wr_strb[0]) begin
				regs.width <= wr_data[WIDTH_LSB +: 2];
			end
		end
	end

	// group top bits come from the even bank
	assign eff_base = {grp_base_top, regs.base_hi[11:0],
		regs.base_lo[15]};
	assign eff_mask = {grp_mask_top, regs.mask_hi[11:0],
		regs.mask_lo[15]};
	assign hit = (((mem_addr[31:CMP_LSB] ^ eff_base) & eff_mask)
		== 17'h00000);

endmodule // mcs_bank

// ===== mcs_decoder.sv
`timescale 1ns/1ps
module mcs_decoder
	import mcs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        interleave_boot,
	input  wire logic [1:0]  boot_width,
	input  mcs_axi_m2s_t     axi_in,
	output mcs_axi_s2m_t     axi_out,
	input  wire logic        mem_cycle,
	input  wire logic [31:0] mem_addr,
	output logic [7:0]       bank_select_n,
	output mcs_sel_t         sel
);

	typedef struct packed {
		mcs_slot_t  slot;
		logic [2:0] bank;
	} mcs_dec_t;

	mcs_bank_regs_t regs [NUM_BANKS];
	logic [7:0]     hit;
	logic [7:0]     hit_adj;
	logic [7:0]     next_select;
	mcs_sel_t       next_sel;
	logic           boot_il;

	logic           aw_held;
	logic [7:0]     aw_addr;
	logic           w_held;
	logic [31:0]    w_data;
	logic [3:0]     w_strb;
	logic           do_write;
	mcs_dec_t       wr_dec;
	mcs_dec_t       rd_dec;
	logic [31:0]    next_rdata;

	// register slot from a byte address
	function automatic mcs_dec_t decode_slot(input logic [7:0] addr);
		mcs_dec_t d;
		logic [7:0] ofs;
		d.bank = addr[7:5];
		ofs = addr & (BANK_STRIDE - 8'h01);
		if (addr == OFS_STATUS) begin
			d.slot = SLOT_STATUS;
		end else if (ofs == OFS_BASE_LO) begin
			d.slot = SLOT_BASE_LO;
		end else if (ofs == OFS_BASE_HI) begin
			d.slot = SLOT_BASE_HI;
		end else if (ofs == OFS_MASK_LO) begin
			d.slot = SLOT_MASK_LO;
		end else if (ofs == OFS_MASK_HI) begin
			d.slot = SLOT_MASK_HI;
		end else if (ofs == OFS_CTRL) begin
			d.slot = SLOT_CTRL;
		end else begin
			d.slot = SLOT_NONE;
		end
		return d;
	endfunction

	// boot strap seen while held in reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			boot_il <= interleave_boot;
		end
	end

	// write address and data taken in either order
	assign axi_out.awready = !aw_held && !axi_out.bvalid;
	assign axi_out.wready  = !w_held && !axi_out.bvalid;
	assign do_write        = aw_held && w_held && !axi_out.bvalid;
	assign wr_dec          = decode_slot(aw_addr);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (axi_in.awvalid && axi_out.awready) begin
			aw_held <= 1'b1;
			aw_addr <= axi_in.awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (axi_in.wvalid && axi_out.wready) begin
			w_held <= 1'b1;
			w_data <= axi_in.wdata;
			w_strb <= axi_in.wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			axi_out.bvalid <= 1'b0;
			axi_out.bresp  <= RESP_OKAY;
		end else if (do_write) begin
			axi_out.bvalid <= 1'b1;
			if (wr_dec.slot == SLOT_NONE || wr_dec.slot == SLOT_STATUS) begin
				axi_out.bresp <= RESP_DECERR;
			end else begin
				axi_out.bresp <= RESP_OKAY;
			end
		end else if (axi_in.bready) begin
			axi_out.bvalid <= 1'b0;
		end
	end

	// the eight banks
	generate
		for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
			localparam int EVEN = b - (b % 2);
			mcs_bank #(
				.BANK(3'(b))
			) u_bank (
				.clk            (clk),
				.rst_b          (rst_b),
				.interleave_boot(interleave_boot),
				.boot_width     (boot_width),
				.wr_en          (do_write && wr_dec.bank == 3'(b)),
				.wr_slot        (wr_dec.slot),
				.wr_data        (w_data[15:0]),
				.wr_strb        (w_strb[1:0]),
				.grp_base_top   (regs[EVEN].base_hi[15:12]),
				.grp_mask_top   (regs[EVEN].mask_hi[15:12]),
				.mem_addr       (mem_addr),
				.regs           (regs[b]),
				.hit            (hit[b])
			);
		end
	endgenerate

	// 64-bit pairs alternate on address bit 2
	generate
		for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_pair
			logic pair_il;
			assign pair_il = regs[2*g].width == WIDTH_64 && hit[2*g]
				&& hit[2*g+1];
			assign hit_adj[2*g]   = hit[2*g] && !(pair_il && mem_addr[2]);
			assign hit_adj[2*g+1] = hit[2*g+1] && !(pair_il && !mem_addr[2]);
		end
	endgenerate

	// lowest-numbered matching bank wins
	always_comb begin
		next_select = 8'h00;
		next_sel    = '{style: STYLE_REG_MEM, width: WIDTH_32};
		if (mem_cycle) begin
			for (int i = NUM_BANKS - 1; i >= 0; i--) begin
				if (hit_adj[i]) begin
					next_select = 8'h01 << i;
					next_sel    = '{style: regs[i].style,
						width: regs[i].width};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bank_select_n <= 8'hFF;
		end else begin
			bank_select_n <= ~next_select;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sel <= '{style: STYLE_REG_MEM, width: WIDTH_32};
		end else begin
			sel <= next_sel;
		end
	end

	// read channel
	assign axi_out.arready = !axi_out.rvalid;
	assign rd_dec          = decode_slot(axi_in.araddr);

	always_comb begin
		next_rdata = 32'h00000000;
		case (rd_dec.slot)
			SLOT_BASE_LO: next_rdata[15:0] = regs[rd_dec.bank].base_lo;
			SLOT_BASE_HI: next_rdata[15:0] = regs[rd_dec.bank].base_hi;
			SLOT_MASK_LO: next_rdata[15:0] = regs[rd_dec.bank].mask_lo;
			SLOT_MASK_HI: next_rdata[15:0] = regs[rd_dec.bank].mask_hi;
			SLOT_CTRL: begin
				next_rdata[STYLE_LSB +: 4] = regs[rd_dec.bank].style;
				next_rdata[WIDTH_LSB +: 2] = regs[rd_dec.bank].width;
			end
			SLOT_STATUS: next_rdata[8:0] = {boot_il, ~bank_select_n};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			axi_out.rvalid <= 1'b0;
			axi_out.rdata  <= 32'h00000000;
			axi_out.rresp  <= RESP_OKAY;
		end else if (axi_in.arvalid && axi_out.arready) begin
			axi_out.rvalid <= 1'b1;
			axi_out.rdata  <= next_rdata;
			if (rd_dec.slot == SLOT_NONE) begin
				axi_out.rresp <= RESP_DECERR;
			end else begin
				axi_out.rresp <= RESP_OKAY;
			end
		end else if (axi_in.rready) begin
			axi_out.rvalid <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic [31:0] base0;
	logic [31:0] base1;
	logic [31:0] mask0;
	assign base0 = {regs[0].base_hi, regs[0].base_lo};
	assign base1 = {regs[1].base_hi, regs[1].base_lo};
	assign mask0 = {regs[0].mask_hi, regs[0].mask_lo};

	sequence s_both_taken;
		aw_held && w_held && !axi_out.bvalid;
	endsequence

	sequence s_resp_given;
		##1 axi_out.bvalid;
	endsequence

	a_select_onehot: assert property (
		$onehot0(~bank_select_n))
		else $error("more than one bank select active");

	a_select_idle: assert property (
		!mem_cycle |=> &bank_select_n)
		else $error("bank select active outside a bus cycle");

	a_select_match: assert property (
		mem_cycle && hit[0] && regs[0].width != WIDTH_64
		|=> !bank_select_n[0])
		else $error("bank 0 matched but not selected");

	a_select_nomatch: assert property (
		!(|hit) |=> &bank_select_n)
		else $error("select fired without an address match");

	a_low_wins: assert property (
		mem_cycle && hit[0] && hit[2] |=> bank_select_n[2])
		else $error("higher bank chosen over lower");

	a_mask_reset: assert property (
		$past(!rst_b) |-> mask0 == 32'hFFFF8000)
		else $error("mask reset value wrong");

	a_base_reset: assert property (
		$past(!rst_b) && !$past(interleave_boot)
		|-> base0 == 32'h1FC00000 && base1 == 32'h1FF00000)
		else $error("base reset value wrong");

	a_base_il: assert property (
		$past(!rst_b) && $past(interleave_boot) |-> base1 == base0)
		else $error("interleaved odd base differs from even");

	a_style_il: assert property (
		$past(!rst_b) && $past(interleave_boot)
		|-> regs[0].style == STYLE_LATCH_MEM)
		else $error("interleaved boot style wrong");

	a_write_resp: assert property (
		s_both_taken |-> s_resp_given)
		else $error("write response not given");

	a_read_resp: assert property (
		axi_in.arvalid && axi_out.arready |=> axi_out.rvalid)
		else $error("read response not given");

endmodule // mcs_decoder

// ===== mcs_mem_model.sv
`timescale 1ns/1ps
module mcs_mem_model
	import mcs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] bank_select_n,
	output logic [2:0]      last_bank
);
	// remembers which device last saw its select
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_bank <= 3'h0;
		end else begin
			for (int i = 7; i >= 0; i--) begin
				if (!bank_select_n[i]) begin
					last_bank <= 3'(i);
				end
			end
		end
	end
endmodule // mcs_mem_model

// ===== mem_chip_select_decoder_bench.sv
`timescale 1ns/1ps
module mem_chip_select_decoder_bench
	import mcs_pkg::*;
;
	logic         clk;
	logic         rst_b;
	logic         interleave_boot;
	logic [1:0]   boot_width;
	mcs_axi_m2s_t axi_in;
	mcs_axi_s2m_t axi_out;
	logic         mem_cycle;
	logic [31:0]  mem_addr;
	logic [7:0]   bank_select_n;
	mcs_sel_t     sel;
	logic [2:0]   last_bank;
	int           num_errors;
	int           samples_checked;

	mcs_decoder dut_u (.clk(clk), .rst_b(rst_b),
		.interleave_boot(interleave_boot), .boot_width(boot_width),
		.axi_in(axi_in), .axi_out(axi_out), .mem_cycle(mem_cycle),
		.mem_addr(mem_addr), .bank_select_n(bank_select_n), .sel(sel));

	mcs_mem_model mem_u (.clk(clk), .rst_b(rst_b),
		.bank_select_n(bank_select_n), .last_bank(last_bank));

	function automatic logic [7:0] r(input int b, input logic [7:0] o);
		return 8'(b) * BANK_STRIDE + o;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
			input logic [1:0] er = RESP_OKAY);
		logic aw;
		logic w;
		int   n;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		@(posedge clk);
		axi_in.awaddr <= a;
		axi_in.wdata <= {16'h0000, d};
		axi_in.wstrb <= 4'hF;
		axi_in.awvalid <= 1'b1;
		axi_in.wvalid <= 1'b1;
		axi_in.bready <= 1'b1;
		while ((aw || w) && n < 50) begin
			@(posedge clk);
			n++;
			if (aw && axi_out.awready === 1'b1) begin
				aw = 1'b0;
				axi_in.awvalid <= 1'b0;
			end
			if (w && axi_out.wready === 1'b1) begin
				w = 1'b0;
				axi_in.wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge clk);
			n++;
		end while (axi_out.bvalid !== 1'b1 && n < 50);
		axi_in.bready <= 1'b0;
		if (n >= 50) begin
			num_errors++;
		end
		chk(32'(axi_out.bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		@(posedge clk);
		axi_in.araddr <= a;
		axi_in.arvalid <= 1'b1;
		axi_in.rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (axi_out.arready !== 1'b1 && n < 50);
		axi_in.arvalid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (axi_out.rvalid !== 1'b1 && n < 50);
		axi_in.rready <= 1'b0;
		if (n >= 50) begin
			num_errors++;
		end
		chk(axi_out.rdata, e);
		chk(32'(axi_out.rresp), 32'(er));
	endtask

	task automatic dec(input logic [31:0] a, input logic [7:0] en,
			input logic [5:0] es);
		@(posedge clk);
		mem_cycle <= 1'b1;
		mem_addr <= a;
		@(posedge clk);
		mem_cycle <= 1'b0;
		#1;
		chk(32'(bank_select_n), 32'(en));
		chk(32'(sel), 32'(es));
		@(posedge clk);
		#1;
		chk(32'(bank_select_n), 32'hFF);
	endtask

	task automatic do_reset(input logic ib, input logic [1:0] bw);
		@(posedge clk);
		interleave_boot <= ib;
		boot_width <= bw;
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
	endtask

	task automatic t_reset_vals();
		logic [15:0] hi;
		for (int b = 0; b < 8; b++) begin
			hi = {4'(b / 2 + 1), (b % 2 == 1) ? 12'hFF0 : 12'hFC0};
			rd(r(b, OFS_BASE_HI), {16'h0000, hi});
			rd(r(b, OFS_BASE_LO), 32'h0);
			rd(r(b, OFS_MASK_HI), 32'hFFFF);
			rd(r(b, OFS_MASK_LO), 32'h8000);
			rd(r(b, OFS_CTRL), 32'h0080);
		end
	endtask

	task automatic t_decode();
		dec(32'h1FC0_0000, 8'hFE, 6'h02);
		dec(32'h1FF0_0000, 8'hFD, 6'h02);
		dec(32'h4FF0_0000, 8'h7F, 6'h02);
		dec(32'h4FC0_7FFC, 8'hBF, 6'h02);
		dec(32'h4FC0_8000, 8'hFF, 6'h00);
	endtask

	task automatic t_fields();
		wr(r(0, OFS_BASE_LO), 16'hFFFF);
		rd(r(0, OFS_BASE_LO), 32'h8000);
		wr(r(0, OFS_MASK_LO), 16'hFFFF);
		rd(r(0, OFS_MASK_LO), 32'hE000);
		dec(32'h1FC0_8000, 8'hFE, 6'h02);
		wr(r(0, OFS_BASE_LO), 16'h0000);
		wr(r(0, OFS_MASK_LO), 16'h8000);
		dec(32'h2FCF_0000, 8'hFF, 6'h00);
		wr(r(2, OFS_MASK_HI), 16'hFFF0);
		dec(32'h2FCF_0000, 8'hFB, 6'h02);
		wr(r(2, OFS_MASK_HI), 16'hFFFF);
	endtask

	task automatic t_group();
		wr(r(3, OFS_BASE_HI), 16'h5FF0);
		rd(r(3, OFS_BASE_HI), 32'h5FF0);
		dec(32'h2FF0_0000, 8'hF7, 6'h02);
		dec(32'h5FF0_0000, 8'hFF, 6'h00);
		wr(r(3, OFS_MASK_HI), 16'h0FFF);
		dec(32'h6FF0_0000, 8'hFF, 6'h00);
		wr(r(2, OFS_BASE_HI), 16'h7FC0);
		dec(32'h7FF0_0000, 8'hF7, 6'h02);
		wr(r(2, OFS_BASE_HI), 16'h2FC0);
		wr(r(1, OFS_BASE_HI), 16'h1FC0);
		dec(32'h1FC0_0000, 8'hFE, 6'h02);
		chk(32'(last_bank), 32'h0);
	endtask

	task automatic t_styles();
		logic [3:0] c [8] = '{4'hB, 4'hA, 4'h9, 4'h8,
			4'h2, 4'h1, 4'h0, 4'hF};
		for (int i = 0; i < 8; i++) begin
			wr(r(0, OFS_CTRL), {4'h0, c[i], 2'(i), 6'h00});
			rd(r(0, OFS_CTRL), {20'h0, c[i], 2'(i), 6'h00});
			dec(32'h1FC0_0000, 8'hFE, {c[i], 2'(i)});
		end
		wr(r(0, OFS_CTRL), 16'h0080);
		wr(r(2, OFS_CTRL), 16'h0180);
		rd(8'h14, 32'h0, RESP_DECERR);
		wr(8'h18, 16'h1234, RESP_DECERR);
		wr(OFS_STATUS, 16'h00FF, RESP_DECERR);
		rd(OFS_STATUS, 32'h0);
	endtask

	task automatic t_interleave();
		do_reset(1'b1, 2'h0);
		rd(r(1, OFS_BASE_HI), 32'h1FC0);
		rd(r(7, OFS_BASE_HI), 32'h4FC0);
		rd(r(0, OFS_CTRL), 32'h02C0);
		rd(OFS_STATUS, 32'h0100);
		dec(32'h1FC0_0004, 8'hFD, 6'h0B);
		dec(32'h1FC0_0000, 8'hFE, 6'h0B);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		rst_b = 1'b0;
		interleave_boot = 1'b0;
		boot_width = 2'h1;
		axi_in = '0;
		mem_cycle = 1'b0;
		mem_addr = 32'h0;
		num_errors = 0;
		samples_checked = 0;
		do_reset(1'b0, 2'h1);
		t_reset_vals();
		t_decode();
		t_fields();
		t_group();
		t_styles();
		t_interleave();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test();
	end
endmodule // mem_chip_select_decoder_bench
